// ### testbench/pccg_pci_tgt.sv
`timescale 1ns/1ps
module pccg_pci_tgt
	import pccg_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire pccg_pci_out_type pci_o,
	input  wire logic             claim,
	input  wire logic [1:0]       lag,
	input  wire logic [31:0]      vec,
	output logic                  trdy_n,
	output logic                  devsel_n,
	output logic [31:0]           ad
);
	logic       hit_q;
	logic [3:0] cmd_q;
	logic [1:0] cnt_q;

	initial begin
		trdy_n = 1'b1;
		devsel_n = 1'b1;
		ad = 32'h5a5a_a5a5;
		hit_q = 1'b0;
	end

	// ********************
	// claim, wait, answer
	// ********************
	// special never claimed, lock never taken
	always @(posedge sys_clk) begin
		if (pci_o.ctl_oe && !pci_o.frame_n && pci_o.irdy_n) begin
			cmd_q <= pci_o.cbe_n;
			hit_q <= claim && (pci_o.cbe_n != CMD_SPECIAL);
			cnt_q <= lag;
			ad <= ~ad;
		end else if (hit_q && pci_o.ctl_oe && !pci_o.irdy_n) begin
			devsel_n <= 1'b0;
			trdy_n <= (cnt_q != 2'h0);
			if (cnt_q != 2'h0)
				cnt_q <= cnt_q - 2'h1;
			ad <= (cnt_q == 2'h0 && cmd_q != CMD_CFG_WR) ? vec : ~ad;
		end else begin
			hit_q <= 1'b0;
			trdy_n <= 1'b1;
			devsel_n <= 1'b1;
			ad <= ~ad; // released lines wander
		end
	end
endmodule // pccg_pci_tgt

// ### testbench/pci_config_cycle_generator_tb.sv
`timescale 1ns/1ps
module pci_config_cycle_generator_tb
	import pccg_pkg::*;
	;
	logic             sys_clk, sys_rst, psel, penable, pwrite;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, vec, t_ad, f_ad, w_ad, rq, a_ad, d_ad;
	logic             pready, pslverr, tgt_cfg_hit, claim, t_trdy_n, t_devsel_n;
	logic             map_b, f_oe, f_frame_n, re, p_exp, af_q, ir_q;
	logic [1:0]       lag;
	logic [3:0]       f_cbe_n, a_cmd;
	pccg_pci_in_type  pci_i;
	pccg_pci_out_type pci_o;
	int               failures, checks_done, cyc, ncyc, hits, n0;

	pccg_cycle_gen #(
		.SELF_DEV(5'h1e),
		.ABORT   (8)
	) uut (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.paddr      (paddr),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.pci_i      (pci_i),
		.pci_o      (pci_o),
		.tgt_cfg_hit(tgt_cfg_hit)
	);

	pccg_pci_tgt tgt (
		.sys_clk (sys_clk),
		.pci_o   (pci_o),
		.claim   (claim),
		.lag     (lag),
		.vec     (vec),
		.trdy_n  (t_trdy_n),
		.devsel_n(t_devsel_n),
		.ad      (t_ad)
	);

	// resolved bus levels, own select on line 30
	always_comb begin
		w_ad = pci_o.ad_oe ? pci_o.ad : (f_oe ? f_ad : t_ad);
		pci_i.ad = w_ad;
		pci_i.cbe_n = pci_o.cbe_oe ? pci_o.cbe_n : f_cbe_n;
		pci_i.frame_n = pci_o.ctl_oe ? pci_o.frame_n : f_frame_n;
		pci_i.trdy_n = t_trdy_n;
		pci_i.devsel_n = t_devsel_n;
		pci_i.idsel = w_ad[30];
		pci_i.map_b = map_b;
	end

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ********************
	// monitor and limit
	// ********************
	// address, first data clock, parity a clock later
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		af_q <= pci_o.ctl_oe && !pci_o.frame_n && pci_o.irdy_n;
		ir_q <= pci_o.irdy_n || !pci_o.ctl_oe;
		if (pci_o.ctl_oe && !pci_o.frame_n && pci_o.irdy_n) begin
			a_ad <= pci_o.ad;
			a_cmd <= pci_o.cbe_n;
			p_exp <= ^{pci_o.ad, pci_o.cbe_n};
			ncyc <= ncyc + 1;
		end
		if (pci_o.ctl_oe && !pci_o.irdy_n && ir_q)
			d_ad <= pci_o.ad;
		if (af_q)
			chk({30'h0, pci_o.par_oe, pci_o.par}, {30'h0, 1'b1, p_exp});
		if (tgt_cfg_hit === 1'b1)
			hits <= hits + 1;
		if (cyc == 20000) begin
			failures++;
			end_of_test();
		end
	end

	// ********************
	// shared tasks
	// ********************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic cfg(input logic [31:0] ca, input logic w, input logic [31:0] d);
		apb(OFS_CFG_ADDR, 1'b1, ca);
		n0 = ncyc;
		apb(OFS_CFG_DATA, w, d);
	endtask

	task automatic do_reset(input logic mb);
		map_b <= mb;
		sys_rst <= 1'b1;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic end_of_test();
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ********************
	// scenarios
	// ********************
	task automatic t_idle();
		n0 = ncyc;
		repeat (40) @(posedge sys_clk);
		chk(32'(ncyc - n0), 32'h0);
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk({31'h0, rq[ST_MAP_B]}, 32'h0);
	endtask

	task automatic t_type0();
		logic [31:0] ex;
		for (int d = 0; d < 31; d++) begin
			vec <= 32'hc0de_0000 + 32'(d);
			lag <= 2'(d % 3);
			ex = 32'h0000_05a8;
			if (d == 10)
				ex[31] = 1'b1;
			if (d > 10)
				ex[d] = 1'b1;
			cfg({16'h8000, 5'(d), 11'h5a8}, 1'b0, 32'h0);
			if (d == 30) begin
				chk(32'(ncyc - n0), 32'h0);
				chk(rq, NOCYC_DATA);
			end else begin
				chk(a_ad, ex);
				chk({28'h0, a_cmd}, {28'h0, CMD_CFG_RD});
				chk(rq, 32'hc0de_0000 + 32'(d));
			end
		end
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk({31'h0, rq[ST_SELF_SKIP]}, 32'h1);
		apb(OFS_STATUS, 1'b1, 32'h8);
		cfg(32'h0000_5800, 1'b0, 32'h0);
		chk(32'(ncyc - n0), 32'h0);
		chk(rq, NOCYC_DATA);
	endtask

	task automatic t_type1();
		logic [31:0] ca;
		for (int k = 0; k < 2; k++) begin
			ca = k ? 32'h8005_ff00 : 32'h80a0_1b44;
			cfg(ca, k[0], 32'ha5a5_0f0f);
			chk(a_ad, {ca[31:2], TYPE1_LOW});
			chk({28'h0, a_cmd}, {28'h0, k ? CMD_CFG_WR : CMD_CFG_RD});
		end
		chk(d_ad, 32'ha5a5_0f0f);
	endtask

	task automatic t_intack();
		vec <= 32'h0000_0047;
		lag <= 2'h2;
		cfg(32'h8000_ff00, 1'b0, 32'h0);
		chk(a_ad, STABLE_AD);
		chk({28'h0, a_cmd}, {28'h0, CMD_INTACK});
		chk(rq, 32'h0000_0047);
		apb(OFS_DIR_ADDR, 1'b1, IACK_A_LO + 32'h8);
		n0 = ncyc;
		apb(OFS_DIR_DATA, 1'b0, 32'h0);
		chk(32'(ncyc - n0), 32'h1);
		chk({28'h0, a_cmd}, {28'h0, CMD_INTACK});
		n0 = ncyc;
		apb(OFS_DIR_DATA, 1'b1, 32'h0);
		chk({31'h0, re}, 32'h1);
		chk(32'(ncyc - n0), 32'h0);
	endtask

	task automatic t_special();
		logic [15:0] msg [4] = '{MSG_SHUTDOWN, MSG_HALT, MSG_X86, 16'h1234};
		for (int k = 0; k < 4; k++) begin
			cfg(32'h8000_ff00, 1'b1, {16'hbe00 + 16'(k), msg[k]});
			chk({28'h0, a_cmd}, {28'h0, CMD_SPECIAL});
			chk(a_ad, STABLE_AD);
			chk(d_ad, {16'hbe00 + 16'(k), msg[k]});
		end
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk({31'h0, rq[ST_MABORT]}, 32'h0);
		claim <= 1'b0;
		cfg(32'h8000_5800, 1'b0, 32'h0);
		chk(rq, NOCYC_DATA);
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk({31'h0, rq[ST_MABORT]}, 32'h1);
		apb(OFS_STATUS, 1'b1, 32'h2);
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk({31'h0, rq[ST_MABORT]}, 32'h0);
		claim <= 1'b1;
	endtask

	task automatic t_direct();
		logic [31:0] da [3] = '{32'h8080_0a04, 32'h80c0_0010, 32'h80ff_f8fc};
		vec <= 32'h1111_2222;
		for (int k = 0; k < 3; k++) begin
			apb(OFS_DIR_ADDR, 1'b1, da[k]);
			n0 = ncyc;
			apb(OFS_DIR_DATA, 1'b0, 32'h0);
			chk(32'(ncyc - n0), 32'h1);
			chk(a_ad, {2'b00, da[k][29:0]});
			chk({31'h0, a_ad[DIR_IDSEL_BIT]}, 32'h1);
			chk(rq, 32'h1111_2222);
		end
		apb(OFS_DIR_ADDR, 1'b1, 32'h8000_0a04);
		n0 = ncyc;
		apb(OFS_DIR_DATA, 1'b0, 32'h0);
		chk({31'h0, re}, 32'h1);
		chk(32'(ncyc - n0), 32'h0);
	endtask

	task automatic t_target();
		logic [3:0] cm [3] = '{CMD_CFG_RD, CMD_INTACK, CMD_SPECIAL};
		int h0;
		for (int k = 0; k < 3; k++) begin
			h0 = hits;
			f_oe <= 1'b1;
			f_ad <= 32'h4000_0000;
			f_cbe_n <= cm[k];
			f_frame_n <= 1'b0;
			@(posedge sys_clk);
			f_oe <= 1'b0;
			f_frame_n <= 1'b1;
			repeat (8) @(posedge sys_clk);
			chk(32'(hits - h0), (k == 0) ? 32'h1 : 32'h0);
		end
	endtask

	task automatic t_mapb();
		apb(OFS_STATUS, 1'b0, 32'h0);
		chk({31'h0, rq[ST_MAP_B]}, 32'h1);
		vec <= 32'h0000_00a3;
		apb(OFS_DIR_ADDR, 1'b1, IACK_B_LO + 32'h0001_2340);
		n0 = ncyc;
		apb(OFS_DIR_DATA, 1'b0, 32'h0);
		chk(32'(ncyc - n0), 32'h1);
		chk({28'h0, a_cmd}, {28'h0, CMD_INTACK});
		chk(rq, 32'h0000_00a3);
		apb(8'h18, 1'b0, 32'h0);
		chk({31'h0, re}, 32'h1);
	endtask

	// main sequence
	initial begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, map_b, f_oe} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		f_frame_n = 1'b1;
		f_cbe_n = 4'hf;
		f_ad = 32'h0;
		claim = 1'b1;
		lag = 2'h0;
		vec = 32'h0;
		do_reset(1'b0);
		t_idle();
		t_type0();
		t_type1();
		t_intack();
		t_special();
		t_direct();
		t_target();
		do_reset(1'b1);
		t_mapb();
		end_of_test();
	end
endmodule // pci_config_cycle_generator_tb

// ### verilog/pccg_cycle_gen.sv
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module pccg_cycle_gen
	import pccg_pkg::*;
#(
	parameter logic [4:0] SELF_DEV = 5'h00,
	parameter int         ABORT    = ABORT_CYCLES
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [7:0]       paddr,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire pccg_pci_in_type  pci_i,
	output pccg_pci_out_type      pci_o,
	output logic                  tgt_cfg_hit
);

	localparam int CW = $clog2(ABORT + 1);

	// ************************************************************
	// idsel line for a type 0 device number
	// ************************************************************
	function automatic logic [31:0] idsel_of(input logic [4:0] dev);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (dev == DEV_WRAP) begin
			v[31] = 1'b1;
		end else if (dev >= DEV_FIRST && dev <= DEV_LAST) begin
			v = 32'h0000_0001 << dev;
		end
		return v;
	endfunction

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	pccg_pci_in_type sync1_q;
	pccg_pci_in_type pin_q;
	logic            frame_prev_q;

	// two stages before any logic looks at the pins
	always_ff @(posedge sys_clk) begin
		sync1_q <= pci_i;
		pin_q   <= sync1_q;
	end

	// ************************************************************
	// software registers
	// ************************************************************
	logic [31:0]    cfg_addr_q;
	logic [31:0]    dir_addr_q;
	logic [3:0]     be_q;
	logic           map_b_q;
	logic           mabort_q;
	logic           self_skip_q;
	pccg_state_type state_q;
	logic           apb_acc;
	logic           trig;
	logic           mapped;

	assign apb_acc = psel && penable;
	assign trig    = (paddr == OFS_CFG_DATA) || (paddr == OFS_DIR_DATA);
	assign mapped  = trig || (paddr == OFS_CFG_ADDR) || (paddr == OFS_DIR_ADDR)
		|| (paddr == OFS_STATUS) || (paddr == OFS_BYTE_EN);

	// address map strap, sampled while reset is high
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			map_b_q <= pin_q.map_b;
		end
	end

	// plain register writes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_addr_q <= RST_WORD;
			dir_addr_q <= RST_WORD;
			be_q       <= BE_RESET;
		end else if (apb_acc && pwrite && state_q == S_IDLE) begin
			if (paddr == OFS_CFG_ADDR) begin
				cfg_addr_q <= pwdata & CA_WMASK; // reserved bits stay zero
			end
			if (paddr == OFS_DIR_ADDR) begin
				dir_addr_q <= pwdata;
			end
			if (paddr == OFS_BYTE_EN) begin
				be_q <= pwdata[3:0];
			end
		end
	end

	// ************************************************************
	// access decode
	// ************************************************************
	logic          ca_en;
	logic [7:0]    ca_bus;
	logic [4:0]    ca_dev;
	logic [2:0]    ca_fn;
	logic [5:0]    ca_reg;
	logic          dec_go;
	logic          dec_err;
	logic          dec_skip;
	pccg_path_type dec_path;
	pccg_cmd_type  dec_cmd;
	logic [31:0]   dec_ad;
	logic [31:0]   self_mask;
	logic          in_dir;
	logic          in_iack;

	assign ca_en     = cfg_addr_q[CA_EN_BIT];
	assign ca_bus    = cfg_addr_q[CA_BUS_MSB:CA_BUS_LSB];
	assign ca_dev    = cfg_addr_q[CA_DEV_MSB:CA_DEV_LSB];
	assign ca_fn     = cfg_addr_q[CA_FN_MSB:CA_FN_LSB];
	assign ca_reg    = cfg_addr_q[CA_REG_MSB:CA_REG_LSB];
	assign self_mask = idsel_of(SELF_DEV);
	assign in_dir    = !map_b_q && dir_addr_q >= DIR_CFG_LO && dir_addr_q <= DIR_CFG_HI;
	assign in_iack   = map_b_q ? (dir_addr_q >= IACK_B_LO && dir_addr_q <= IACK_B_HI)
		: (dir_addr_q >= IACK_A_LO && dir_addr_q <= IACK_A_HI);

	// which cycle a data window access turns into
	always_comb begin
		dec_go   = 1'b0;
		dec_err  = 1'b0;
		dec_path = PATH_T0;
		dec_cmd  = pwrite ? CMD_CFG_WR : CMD_CFG_RD;
		dec_ad   = STABLE_AD;
		if (paddr == OFS_CFG_DATA) begin
			if (ca_en) begin
				if (ca_bus != BUS_LOCAL) begin
					dec_go   = 1'b1;
					dec_path = PATH_T1;
					dec_ad   = {cfg_addr_q[31:2], TYPE1_LOW};
				end else if (ca_dev == DEV_ALL_ONES) begin
					if (ca_fn == FN_ALL_ONES && ca_reg == REG_ZERO) begin
						dec_go   = 1'b1;
						dec_path = pwrite ? PATH_SPEC : PATH_IACK;
						dec_cmd  = pwrite ? CMD_SPECIAL : CMD_INTACK;
					end
				end else begin
					dec_go   = 1'b1;
					dec_path = PATH_T0;
					dec_ad   = idsel_of(ca_dev) | {21'h0, ca_fn, ca_reg, TYPE0_LOW};
				end
			end
		end else if (paddr == OFS_DIR_DATA) begin
			if (in_dir) begin
				dec_go   = 1'b1;
				dec_path = PATH_DIR;
				dec_ad   = {2'b00, dir_addr_q[29:0]};
			end else if (in_iack) begin
				dec_go   = !pwrite;
				dec_err  = pwrite;
				dec_path = PATH_IACK;
				dec_cmd  = CMD_INTACK;
			end else begin
				dec_err = 1'b1;
			end
		end
	end

	// a cycle whose idsel would hit our own line is dropped
	assign dec_skip = (dec_path == PATH_T0 || dec_path == PATH_DIR)
		&& |(dec_ad & self_mask);

	// ************************************************************
	// master sequencer
	// ************************************************************
	pccg_path_type path_q;
	pccg_cmd_type  cmd_q;
	logic [31:0]   addr_q;
	logic [31:0]   wdata_q;
	logic [31:0]   rdata_q;
	logic          wr_q;
	logic          err_q;
	logic [CW-1:0] cnt_q;
	logic          start;
	logic          timeout;

	assign start   = apb_acc && trig && state_q == S_IDLE;
	assign timeout = cnt_q == CW'(ABORT - 1);

	// state, transaction fields and answer
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= S_IDLE;
			path_q  <= PATH_T0;
			cmd_q   <= CMD_CFG_RD;
			addr_q  <= STABLE_AD;
			wdata_q <= RST_WORD;
			rdata_q <= RST_WORD;
			wr_q    <= 1'b0;
			err_q   <= 1'b0;
			cnt_q   <= '0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (start) begin
						path_q  <= dec_path;
						cmd_q   <= dec_cmd;
						addr_q  <= dec_ad;
						wdata_q <= pwdata;
						wr_q    <= pwrite;
						err_q   <= dec_err;
						rdata_q <= NOCYC_DATA;
						cnt_q   <= '0;
						state_q <= (dec_go && !dec_skip) ? S_ADDR : S_DONE;
					end
				end
				S_ADDR: begin
					state_q <= S_DATA;
				end
				S_DATA: begin
					cnt_q <= cnt_q + CW'(1);
					if (!pin_q.trdy_n && path_q != PATH_SPEC) begin
						if (!wr_q) begin
							rdata_q <= pin_q.ad;
						end
						state_q <= S_DONE;
					end else if (timeout) begin
						state_q <= S_DONE;
					end
				end
				S_DONE: begin
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// sticky status, set wins over the write-one clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mabort_q    <= 1'b0;
			self_skip_q <= 1'b0;
		end else begin
			if (apb_acc && pwrite && state_q == S_IDLE && paddr == OFS_STATUS) begin
				mabort_q    <= mabort_q & ~pwdata[ST_MABORT];
				self_skip_q <= self_skip_q & ~pwdata[ST_SELF_SKIP];
			end
			if (state_q == S_DATA && timeout && pin_q.trdy_n && path_q != PATH_SPEC) begin
				mabort_q <= 1'b1;
			end
			if (start && dec_go && dec_skip) begin
				self_skip_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// apb answer
	// ************************************************************
	always_comb begin
		pready  = 1'b0;
		pslverr = 1'b0;
		prdata  = RST_WORD;
		if (state_q == S_DONE) begin
			pready  = 1'b1;
			pslverr = err_q;
			prdata  = wr_q ? RST_WORD : rdata_q;
		end else if (apb_acc && state_q == S_IDLE && !trig) begin
			pready  = 1'b1;
			pslverr = !mapped;
			case (paddr)
				OFS_CFG_ADDR: prdata = cfg_addr_q;
				OFS_DIR_ADDR: prdata = dir_addr_q;
				OFS_BYTE_EN:  prdata = {28'h0, be_q};
				OFS_STATUS: begin
					prdata[ST_MABORT]    = mabort_q;
					prdata[ST_MAP_B]     = map_b_q;
					prdata[ST_SELF_SKIP] = self_skip_q;
				end
				default:      prdata = RST_WORD;
			endcase
		end else if (apb_acc && state_q == S_IDLE) begin
			prdata[ST_BUSY] = 1'b0;
		end
	end

	// ************************************************************
	// pci pins
	// ************************************************************
	logic par_q;
	logic par_oe_q;
	logic par_src;

	// address phase, then one data phase with frame released
	always_comb begin
		pci_o         = '0;
		pci_o.frame_n = 1'b1;
		pci_o.irdy_n  = 1'b1;
		pci_o.cbe_n   = cmd_q;
		pci_o.ctl_oe  = state_q != S_IDLE;
		if (state_q == S_ADDR) begin
			pci_o.frame_n = 1'b0;
			pci_o.ad      = addr_q;
			pci_o.ad_oe   = 1'b1;
			pci_o.cbe_oe  = 1'b1;
		end else if (state_q == S_DATA) begin
			pci_o.irdy_n = 1'b0;
			pci_o.cbe_n  = (path_q == PATH_SPEC) ? SPEC_BE : be_q;
			pci_o.cbe_oe = 1'b1;
			pci_o.ad     = wr_q ? wdata_q : STABLE_AD;
			pci_o.ad_oe  = wr_q;
		end
		pci_o.par    = par_q;
		pci_o.par_oe = par_oe_q;
	end

	assign par_src = ^{pci_o.ad, pci_o.cbe_n};

	// even parity one clock after the driven phase
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			par_q    <= 1'b0;
			par_oe_q <= 1'b0;
		end else begin
			par_q    <= par_src;
			par_oe_q <= pci_o.ad_oe;
		end
	end

	// ************************************************************
	// target side: only config commands with idsel are claimed
	// ************************************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			frame_prev_q <= 1'b1;
			tgt_cfg_hit  <= 1'b0;
		end else begin
			frame_prev_q <= pin_q.frame_n;
			tgt_cfg_hit  <= frame_prev_q && !pin_q.frame_n && pin_q.idsel
				&& state_q == S_IDLE
				&& (pin_q.cbe_n == CMD_CFG_RD || pin_q.cbe_n == CMD_CFG_WR);
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_cfg_enable_gate: assert property (
		start && paddr == OFS_CFG_DATA && !ca_en |=> state_q == S_DONE)
		else $error("window access started a cycle while disabled");
	a_type0_idsel_map: assert property (
		state_q == S_ADDR && path_q == PATH_T0 |-> addr_q == (idsel_of(ca_dev) | {21'h0, addr_q[10:0]}))
		else $error("type 0 idsel line wrong");
	a_no_self_cfg: assert property (
		state_q == S_ADDR |-> (path_q != PATH_T0 && path_q != PATH_DIR) || !(|(pci_o.ad & self_mask)))
		else $error("cycle addressed own idsel");
	a_type0_low_bits: assert property (
		state_q == S_ADDR && path_q == PATH_T0 |-> pci_o.ad[10:0] == {ca_fn, ca_reg, TYPE0_LOW})
		else $error("type 0 low address lines wrong");
	a_direct_addr: assert property (
		state_q == S_ADDR && path_q == PATH_DIR
		|-> pci_o.ad == {2'b00, dir_addr_q[29:0]} && pci_o.ad[DIR_IDSEL_BIT])
		else $error("direct config address wrong");
	a_type1_addr: assert property (
		state_q == S_ADDR && path_q == PATH_T1 |-> pci_o.ad == {cfg_addr_q[31:2], TYPE1_LOW})
		else $error("type 1 address wrong");
	a_iack_phase: assert property (
		state_q == S_ADDR && path_q == PATH_IACK
		|-> pci_o.cbe_n == CMD_INTACK && pci_o.ad == STABLE_AD && !wr_q ##1 state_q == S_DATA)
		else $error("intack address phase wrong");
	a_iack_write_err: assert property (
		start && paddr == OFS_DIR_DATA && pwrite && !in_dir && in_iack |=> pready && pslverr)
		else $error("write to intack window not refused");
	a_special_data: assert property (
		state_q == S_DATA && path_q == PATH_SPEC
		|-> pci_o.ad == wdata_q && !pci_o.irdy_n && pci_o.ad_oe
		&& ($past(state_q) != S_DATA || $stable(pci_o.ad)))
		else $error("special message not on first irdy clock");
	a_special_no_abort: assert property (
		state_q == S_DATA && path_q == PATH_SPEC && !mabort_q |=> !mabort_q)
		else $error("special cycle set master abort");
	a_no_auto_special: assert property (
		state_q == S_ADDR && path_q == PATH_SPEC |-> $past(start) && $past(pwrite))
		else $error("special cycle without software write");
	a_strap_held: assert property (
		state_q != S_IDLE |-> $stable(map_b_q))
		else $error("map select changed while running");
	a_addr_parity: assert property (
		state_q == S_ADDR |=> pci_o.par_oe && pci_o.par == $past(par_src))
		else $error("address parity wrong");

	c_type0_read:  cover property (state_q == S_ADDR && path_q == PATH_T0 && !wr_q);
	c_type1_write: cover property (state_q == S_ADDR && path_q == PATH_T1 && wr_q);
	c_iack_vector: cover property (state_q == S_DATA && path_q == PATH_IACK && !pin_q.trdy_n);
	c_special_end: cover property (state_q == S_DATA && path_q == PATH_SPEC ##1 state_q == S_DONE);

endmodule // pccg_cycle_gen

// ### verilog/pccg_pkg.sv
// How it works
// - translate window only while enable set
// - type 0 device number picks IDSEL line
// - never configure own IDSEL line
// - function and register copied to AD[10:2]
// - type 0 drives AD[1:0] to 00
// - direct window clears MSB, keeps 30 bits
// - direct cycles always assert AD23
// - type 1 copies upper 30 bits, low 01
// - as target ignore intack and special
// - data read with magic pattern: intack
// - nonlocal bus always gives type 1
// - intack command 0000, stable AD, parity
// - intack window reads cycle, writes error
// - data write with magic pattern: special
// - special command 0001, stable AD, parity
// - message low half, data high half
// - codes: shutdown, halt, x86 specific
// - no automatic special cycle on sleep
// - special data valid first IRDY clock
// - special ends by abort, no status
package pccg_pkg;

	// ************************************************************
	// register map and fields
	// ************************************************************
	localparam logic [7:0]  OFS_CFG_ADDR  = 8'h00;
	localparam logic [7:0]  OFS_CFG_DATA  = 8'h04;
	localparam logic [7:0]  OFS_DIR_ADDR  = 8'h08;
	localparam logic [7:0]  OFS_DIR_DATA  = 8'h0c;
	localparam logic [7:0]  OFS_STATUS    = 8'h10;
	localparam logic [7:0]  OFS_BYTE_EN   = 8'h14;
	localparam int          CA_EN_BIT     = 31;
	localparam int          CA_BUS_MSB    = 23;
	localparam int          CA_BUS_LSB    = 16;
	localparam int          CA_DEV_MSB    = 15;
	localparam int          CA_DEV_LSB    = 11;
	localparam int          CA_FN_MSB     = 10;
	localparam int          CA_FN_LSB     = 8;
	localparam int          CA_REG_MSB    = 7;
	localparam int          CA_REG_LSB    = 2;
	localparam logic [31:0] CA_WMASK      = 32'h80ff_fffc;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [3:0]  BE_RESET      = 4'h0;
	localparam int          ST_BUSY       = 0;
	localparam int          ST_MABORT     = 1;
	localparam int          ST_MAP_B      = 2;
	localparam int          ST_SELF_SKIP  = 3;

	// ************************************************************
	// decode constants
	// ************************************************************
	localparam logic [7:0]  BUS_LOCAL     = 8'h00;
	localparam logic [4:0]  DEV_ALL_ONES  = 5'h1f;
	localparam logic [4:0]  DEV_WRAP      = 5'h0a;
	localparam logic [4:0]  DEV_FIRST     = 5'h0b;
	localparam logic [4:0]  DEV_LAST      = 5'h1e;
	localparam logic [2:0]  FN_ALL_ONES   = 3'h7;
	localparam logic [5:0]  REG_ZERO      = 6'h00;
	localparam logic [1:0]  TYPE0_LOW     = 2'h0;
	localparam logic [1:0]  TYPE1_LOW     = 2'h1;
	localparam logic [31:0] DIR_CFG_LO    = 32'h8080_0000;
	localparam logic [31:0] DIR_CFG_HI    = 32'h80ff_ffff;
	localparam logic [31:0] IACK_A_LO     = 32'hbfff_fff0;
	localparam logic [31:0] IACK_A_HI     = 32'hbfff_ffff;
	localparam logic [31:0] IACK_B_LO     = 32'hfef0_0000;
	localparam logic [31:0] IACK_B_HI     = 32'hfeff_ffff;
	localparam int          DIR_IDSEL_BIT = 23;
	localparam logic [31:0] STABLE_AD     = 32'h0000_0000;
	localparam logic [31:0] NOCYC_DATA    = 32'hffff_ffff;
	localparam logic [15:0] MSG_SHUTDOWN  = 16'h0000;
	localparam logic [15:0] MSG_HALT      = 16'h0001;
	localparam logic [15:0] MSG_X86       = 16'h0002;
	localparam logic [3:0]  SPEC_BE       = 4'h0;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_NS       = 4;
	localparam int ABORT_NS     = 24;
	localparam int ABORT_CYCLES = (ABORT_NS + CLK_NS - 1) / CLK_NS;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [3:0] {
		CMD_INTACK  = 4'h0,
		CMD_SPECIAL = 4'h1,
		CMD_CFG_RD  = 4'ha,
		CMD_CFG_WR  = 4'hb
	} pccg_cmd_type;

	typedef enum logic [2:0] {
		PATH_T0   = 3'h0,
		PATH_T1   = 3'h1,
		PATH_DIR  = 3'h2,
		PATH_IACK = 3'h3,
		PATH_SPEC = 3'h4
	} pccg_path_type;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ADDR = 2'b01,
		S_DATA = 2'b11,
		S_DONE = 2'b10
	} pccg_state_type;

	typedef struct packed {
		logic [31:0] ad;
		logic        ad_oe;
		logic [3:0]  cbe_n;
		logic        cbe_oe;
		logic        frame_n;
		logic        irdy_n;
		logic        ctl_oe;
		logic        par;
		logic        par_oe;
	} pccg_pci_out_type;

	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe_n;
		logic        frame_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        idsel;
		logic        map_b;
	} pccg_pci_in_type;

endpackage
